/* File: design/qdrc_top.sv */
// Purpose: reference state control and channel code registers of a quad converter
// Assumes: host drives frame-select low, data on falling link clock edges
// Notes:   analog path modelled by tap select and reference enable outputs
module qdrc_top (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// serial link pins
	input  wire logic         sclk,
	input  wire logic         frame_n,
	input  wire logic         din,
	// reference pin drive
	output logic              reference_output_pin_o,
	output logic              reference_output_pin_oe,
	output logic              ref_powered,
	output qdrc_pkg::qdrc_ref_mode_t ref_mode,
	// channel state
	output logic [63:0]       tap_select,
	output logic [3:0]        chan_powered_down
);

	logic        rst_meta_q;          // reset release stage one
	logic        rst_n_q;             // reset release stage two
	logic [2:0]  pin_meta_q;          // link pins stage one
	logic [2:0]  pin_sync_q;          // link pins stage two
	qdrc_pkg::qdrc_cmd_t cmd;         // received command pulse
	qdrc_pkg::qdrc_ref_mode_t mode_q; // reference state
	logic [15:0] code_q [4];          // converter registers
	logic [15:0] buf_q  [4];          // data buffers
	logic [3:0]  pd_q;                // channel power-down flags
	logic [3:0]  pd_buf_q;            // buffered power-down flags
	logic        ref_on;              // reference powered now

	// true when the word is a reference control command
	function automatic logic is_ref_cmd(input logic [23:0] w);
		is_ref_cmd = (w == qdrc_pkg::REF_DEFAULT_WORD) ||
			(w == qdrc_pkg::REF_ALWAYS_WORD) ||
			(w == qdrc_pkg::REF_DISABLE_WORD);
	endfunction : is_ref_cmd

	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// link pins through two flops
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_meta_q <= 3'h2;
			pin_sync_q <= 3'h2;
		end else begin
			pin_meta_q <= {din, frame_n, sclk};
			pin_sync_q <= pin_meta_q;
		end
	end

	// serial front end
	qdrc_serial_rx u_rx (
		.clk       (clk),
		.rst_n     (rst_n_q),
		.sclk_s    (pin_sync_q[0]),
		.frame_n_s (pin_sync_q[1]),
		.din_s     (pin_sync_q[2]),
		.cmd       (cmd)
	);

	// reference state machine
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= qdrc_pkg::QDRC_REF_AUTO;
		end else if (cmd.valid) begin
			case (cmd.word)
				qdrc_pkg::REF_DEFAULT_WORD: mode_q <= qdrc_pkg::QDRC_REF_AUTO;
				qdrc_pkg::REF_ALWAYS_WORD:  mode_q <= qdrc_pkg::QDRC_REF_ALWAYS;
				qdrc_pkg::REF_DISABLE_WORD: mode_q <= qdrc_pkg::QDRC_REF_OFF;
				default:                    mode_q <= mode_q;
			endcase
		end
	end

	// channel data and power-down loading
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int i = 0; i < 4; i++) begin
				code_q[i] <= qdrc_pkg::CODE_RESET;
				buf_q[i]  <= qdrc_pkg::CODE_RESET;
			end
			pd_q     <= 4'h0;
			pd_buf_q <= 4'h0;
		end else if (cmd.valid && !is_ref_cmd(cmd.word)) begin
			logic [1:0] sel;
			logic       pdn;
			logic       ld_hi;
			logic       ld_lo;
			sel   = cmd.word[qdrc_pkg::CHSEL_HI_POS:qdrc_pkg::CHSEL_LO_POS];
			pdn   = cmd.word[qdrc_pkg::PD_SEL_POS];
			ld_hi = cmd.word[qdrc_pkg::LOAD_HI_POS];
			ld_lo = cmd.word[qdrc_pkg::LOAD_LO_POS];
			// data buffer always takes the word
			buf_q[sel]    <= cmd.word[15:0];
			pd_buf_q[sel] <= pdn;
			if (ld_hi) begin
				// simultaneous update: others from buffers
				for (int i = 0; i < 4; i++) begin
					code_q[i] <= buf_q[i];
					pd_q[i]   <= pd_buf_q[i];
				end
				code_q[sel] <= cmd.word[15:0];
				pd_q[sel]   <= pdn;
			end else if (ld_lo) begin
				// single-channel update
				code_q[sel] <= cmd.word[15:0];
				pd_q[sel]   <= pdn;
			end
		end
	end

	// reference power decision
	always_comb begin
		case (mode_q)
			qdrc_pkg::QDRC_REF_AUTO:   ref_on = ~&pd_q;
			qdrc_pkg::QDRC_REF_ALWAYS: ref_on = 1'b1;
			default:                   ref_on = 1'b0;
		endcase
	end

	// outputs
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			tap_select[16*i +: 16] = code_q[i];
		end
	end
	assign ref_powered             = ref_on;
	assign ref_mode                = mode_q;
	assign chan_powered_down       = pd_q;
	assign reference_output_pin_o  = ref_on;
	assign reference_output_pin_oe = ref_on;

endmodule : qdrc_top

/* File: pkg/qdrc_pkg.sv */
// Purpose: shared constants and types for the quad converter reference control
// Assumes: 50 MHz system clock, serial link sampled by that clock
// Notes:   command words are 24 bits, most significant bit first
package qdrc_pkg;

	// serial word geometry
	localparam int unsigned FRAME_BITS   = 24;
	localparam int unsigned CODE_BITS    = 16;
	localparam int unsigned CHANNELS     = 4;
	localparam int unsigned CNT_BITS     = 5;

	// command word fields
	localparam int unsigned PD_SEL_POS   = 16;          // power_down_select_bit
	localparam int unsigned LOAD_HI_POS  = 21;
	localparam int unsigned LOAD_LO_POS  = 20;
	localparam int unsigned CHSEL_HI_POS = 18;
	localparam int unsigned CHSEL_LO_POS = 17;
	localparam int unsigned PDMODE_HI    = 15;
	localparam int unsigned PDMODE_LO    = 14;

	// reference control words
	localparam logic [23:0] REF_DEFAULT_WORD  = 24'h010000;
	localparam logic [23:0] REF_ALWAYS_WORD   = 24'h011000;
	localparam logic [23:0] REF_DISABLE_WORD  = 24'h012000;

	// reset values
	localparam logic [15:0] CODE_RESET        = 16'h0000;
	localparam logic [23:0] SHIFT_RESET       = 24'h000000;

	// reference operating state
	typedef enum logic [1:0] {
		QDRC_REF_AUTO,
		QDRC_REF_ALWAYS,
		QDRC_REF_OFF
	} qdrc_ref_mode_t;

	// one decoded command handed from the serial front end
	typedef struct packed {
		logic        valid;
		logic [23:0] word;
	} qdrc_cmd_t;

endpackage : qdrc_pkg

/* File: design/qdrc_serial_rx.sv */
// Purpose: serial receiver, 24-bit shift register clocked by sampled link edges
// Assumes: link pins already pass two flip-flops in the top module
// Notes:   emits one command pulse on the 24th falling edge of the link clock
module qdrc_serial_rx (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// synchronised link pins
	input  wire logic              sclk_s,
	input  wire logic              frame_n_s,
	input  wire logic              din_s,
	// command out
	output qdrc_pkg::qdrc_cmd_t    cmd
);

	logic                          sclk_prev_q;   // last sampled link clock
	logic                          frame_prev_q;  // last sampled frame line
	logic [23:0]                   shift_q;       // received bits
	logic [qdrc_pkg::CNT_BITS-1:0] count_q;       // bits received this frame
	logic                          locked_q;      // frame done, ignore clocking
	qdrc_pkg::qdrc_cmd_t           cmd_q;         // registered command pulse
	logic                          fall;          // falling link edge in frame
	logic                          frame_start;   // frame line falling edge

	assign fall        = sclk_prev_q & ~sclk_s & ~frame_n_s;
	assign frame_start = frame_prev_q & ~frame_n_s;
	assign cmd         = cmd_q;

	// edge history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q  <= 1'b0;
			frame_prev_q <= 1'b1;
		end else begin
			sclk_prev_q  <= sclk_s;
			frame_prev_q <= frame_n_s;
		end
	end

	// shifting and locking
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q  <= qdrc_pkg::SHIFT_RESET;
			count_q  <= '0;
			locked_q <= 1'b0;
			cmd_q    <= '0;
		end else begin
			cmd_q.valid <= 1'b0;
			if (frame_n_s || frame_start) begin
				// early rise or new frame clears the interface, no transfer
				count_q  <= '0;
				locked_q <= 1'b0;
			end else if (fall && !locked_q) begin
				// msb first into the shift register
				shift_q <= {shift_q[22:0], din_s};
				if (count_q == 5'(qdrc_pkg::FRAME_BITS - 1)) begin
					// 24th edge: lock and execute at once
					locked_q   <= 1'b1;
					cmd_q.valid <= 1'b1;
					cmd_q.word  <= {shift_q[22:0], din_s};
				end
				count_q <= count_q + 5'h01;
			end
		end
	end

endmodule : qdrc_serial_rx

/* File: verification/qdrc_properties.sv */
// Purpose: port-level checks of reference state and channel registers
// Assumes: one clock domain, active-low reset
// Notes:   eight idle cycles cover the sync and apply latency
module qdrc_properties (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     reset_n,
	// link frame pin
	input wire logic                     frame_n,
	// observed outputs
	input wire logic                     reference_output_pin_oe,
	input wire logic                     ref_powered,
	input wire qdrc_pkg::qdrc_ref_mode_t ref_mode,
	input wire logic [63:0]              tap_select,
	input wire logic [3:0]               chan_powered_down
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	pin_follows_mode_a: assert property (reference_output_pin_oe ==
		(ref_powered && ref_mode != qdrc_pkg::QDRC_REF_OFF))
		else $error("pin enable disagrees with mode");
	always_keeps_power_a: assert property (ref_mode == qdrc_pkg::QDRC_REF_ALWAYS
		|-> ref_powered) else $error("always-on reference not powered");
	auto_follows_chans_a: assert property (ref_mode == qdrc_pkg::QDRC_REF_AUTO
		|-> ref_powered == !(&chan_powered_down)) else $error("auto power wrong");
	off_unpowered_a: assert property (ref_mode == qdrc_pkg::QDRC_REF_OFF
		|-> !ref_powered) else $error("disabled reference still powered");
	reset_state_a: assert property ($rose(reset_n) |-> ref_mode == qdrc_pkg::QDRC_REF_AUTO
		&& tap_select == 64'h0 && ref_powered) else $error("bad state after reset");
	idle_mode_hold_a: assert property (frame_n [*8] |-> $stable(ref_mode))
		else $error("mode moved without a frame");
	idle_code_hold_a: assert property (frame_n [*8] |-> $stable(tap_select)
		&& $stable(chan_powered_down)) else $error("channels moved without a frame");
	mode_legal_a: assert property (ref_mode != 2'h3)
		else $error("illegal reference mode");

	// main scenarios reached
	cover property (ref_mode == qdrc_pkg::QDRC_REF_OFF);
	cover property (ref_mode == qdrc_pkg::QDRC_REF_ALWAYS && &chan_powered_down);
	cover property (ref_mode == qdrc_pkg::QDRC_REF_AUTO && !ref_powered);
endmodule : qdrc_properties

/* File: verification/qdrc_host_model.sv */
// Purpose: host serial port driving command frames
// Assumes: link clock stands high outside frames
// Notes:   bits past the 24th are filler to probe the lock
module qdrc_host_model (
	// pacing clock
	input wire logic clk,
	// link pins
	output logic     sclk,
	output logic     frame_n,
	output logic     din,
	// toggles once per finished frame
	output logic     sent
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b1;
		frame_n = 1'b1;
		din = 1'b0;
		sent = 1'b0;
	end
	// msb first, data set while link clock high, 160 ns period off clk phase
	task automatic send(input logic [23:0] w, input int n);
		@(negedge clk);
		#3;
		frame_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			din = (i < 24) ? w[23 - i] : 1'($urandom);
			#80 sclk = 1'b0;
			#80 sclk = 1'b1;
		end
		#80 frame_n = 1'b1;
		din = ~din; // released line never shows the last bit
		sent = ~sent;
		#120;
	endtask : send
endmodule : qdrc_host_model

/* File: verification/qdrc_testbench.sv */
// Purpose: self-checking bench for the reference control top
// Assumes: commands applied within a few clocks of the 24th edge
// Notes:   power-down words still load their data field into the buffer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, sclk, frame_n, din, sent, pin_o, pin_oe, powered;
	qdrc_pkg::qdrc_ref_mode_t mode, e_mode;
	logic [63:0] taps;
	logic [3:0]  pd, e_pd, e_bpd;
	logic [15:0] e_code [4];
	logic [15:0] e_buf [4];
	logic [70:0] notes [$];
	logic [70:0] exp;
	int          mismatches, total_checks;

	qdrc_top uut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .frame_n(frame_n), .din(din),
		.reference_output_pin_o(pin_o), .reference_output_pin_oe(pin_oe),
		.ref_powered(powered), .ref_mode(mode), .tap_select(taps), .chan_powered_down(pd));
	qdrc_host_model host (.clk(clk), .sclk(sclk), .frame_n(frame_n), .din(din), .sent(sent));

	initial clk = 1'b0;
	always #10 clk = ~clk;

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] e);
		total_checks++;
		if (seen !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, e, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	function automatic logic [23:0] mk(logic [1:0] ld, logic [1:0] ch, logic p, logic [15:0] d);
		return {2'h0, ld, 1'b0, ch, p, d};
	endfunction : mk

	// model the word, send it, note the expected state
	task automatic xfer(input logic [23:0] w, input int n);
		logic [1:0] c;
		c = w[18:17];
		if (n < 24) ; // aborted frame changes nothing
		else if (w == qdrc_pkg::REF_DEFAULT_WORD) e_mode = qdrc_pkg::QDRC_REF_AUTO;
		else if (w == qdrc_pkg::REF_ALWAYS_WORD) e_mode = qdrc_pkg::QDRC_REF_ALWAYS;
		else if (w == qdrc_pkg::REF_DISABLE_WORD) e_mode = qdrc_pkg::QDRC_REF_OFF;
		else begin
			e_buf[c] = w[15:0];
			e_bpd[c] = w[16];
			for (int k = 0; k < 4; k++) begin
				if (w[21] || (w[20] && k == c)) begin
					e_code[k] = e_buf[k];
					e_pd[k] = e_bpd[k];
				end
			end
		end
		host.send(w, n);
		notes.push_back({e_mode, e_mode == qdrc_pkg::QDRC_REF_ALWAYS ||
			(e_mode == qdrc_pkg::QDRC_REF_AUTO && !(&e_pd)), e_pd,
			e_code[3], e_code[2], e_code[1], e_code[0]});
	endtask : xfer

	// compare settled outputs after each frame
	initial begin
		forever begin
			@(sent);
			repeat (8) @(negedge clk);
			exp = notes.pop_front();
			check("ref_mode", 64'(mode), 64'(exp[70:69]));
			check("ref_powered", 64'(powered), 64'(exp[68]));
			check("pin_oe", 64'(pin_oe), 64'(exp[68]));
			check("pin_o", 64'(pin_o), 64'(exp[68]));
			check("chan_pd", 64'(pd), 64'(exp[67:64]));
			check("tap_select", taps, exp[63:0]);
		end
	end

	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(32'ha79a));
		reset_n = 1'b0;
		e_mode = qdrc_pkg::QDRC_REF_AUTO;
		e_code = '{4{16'h0000}};
		e_buf = '{4{16'h0000}};
		e_pd = 4'h0;
		e_bpd = 4'h0;
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		check("mode after reset", 64'(mode), 64'(qdrc_pkg::QDRC_REF_AUTO));
		check("power after reset", 64'(powered), 64'h1);
		for (int i = 0; i < 8; i++)
			xfer(mk(2'h1, 2'(i), 1'b0, (i == 7) ? 16'hffff : 16'($urandom)), 24);
		xfer(mk(2'h0, 2'h2, 1'b0, 16'h8000), 24);
		xfer(mk(2'h2, 2'h0, 1'b0, 16'h0001), 24);
		xfer(qdrc_pkg::REF_DISABLE_WORD, 24);
		xfer(qdrc_pkg::REF_DEFAULT_WORD, 23);
		xfer(qdrc_pkg::REF_DEFAULT_WORD, 24);
		for (int i = 0; i < 4; i++)
			xfer(mk(2'h1, 2'(i), 1'b1, 16'h4000), 24);
		xfer(qdrc_pkg::REF_ALWAYS_WORD, 24);
		xfer(qdrc_pkg::REF_DEFAULT_WORD, 24);
		xfer(mk(2'h1, 2'h1, 1'b0, 16'($urandom)), 28);
		xfer(qdrc_pkg::REF_DISABLE_WORD, 26);
		for (int k = 0; k < 100 && notes.size() > 0; k++)
			@(negedge clk);
		if (notes.size() > 0)
			mismatches++;
		tally_and_finish();
	end
endmodule : testbench

bind qdrc_top qdrc_properties u_props (.clk(clk), .reset_n(reset_n), .frame_n(frame_n),
	.reference_output_pin_oe(reference_output_pin_oe), .ref_powered(ref_powered),
	.ref_mode(ref_mode), .tap_select(tap_select), .chan_powered_down(chan_powered_down));
